// *** include/ppw_pkg.sv ***
// What this block does
// RULE1 - software selects up count in this mode
// RULE2 - active edge copies counter into capture register
// RULE3 - active edge reloads counter from reload value
// RULE4 - request on overflow tick and measured edges
// RULE5 - overflow sets flag, counting carries on
// RULE6 - sixteen bit up counter with reload register
// RULE7 - count source field picks clock or pin
// RULE8 - external count pin at most half clock
// RULE9 - capture register writable only while stopped
// RULE10 - input type and mode bit select measurement
// RULE11 - terminal count control picks end condition
// RULE12 - edge field picks period or width
// RULE13 - flags change only with mask bit written
// RULE14 - first edge silent, later edges need enable
// RULE15 - overflow flag only marks counter overflow
// RULE16 - software range checks measured values
// RULE17 - enable bit starts and stops counting
// RULE18 - counter steps on synchronised source edges
package ppw_pkg;
  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_RELOAD = 8'h08;
  localparam logic [7:0] OFF_CMPRLD = 8'h0c;
  localparam logic [7:0] OFF_COUNT = 8'h10;
  localparam logic [7:0] OFF_ISTAT = 8'h14;
  localparam logic [7:0] OFF_IEN = 8'h18;
  localparam logic [7:0] OFF_ICLR = 8'h1c;
  // mode word field positions
  localparam int POS_TYPE = 16;
  localparam int POS_OPMODE = 17;
  localparam int POS_TCC = 18;
  localparam int POS_EDGE_LO = 21;
  localparam int POS_FMASK = 24;
  localparam int POS_UFLAG = 25;
  localparam int POS_OFLAG = 26;
  localparam int POS_DIR = 28;
  localparam int POS_CSRC_LO = 29;
  // mode bits that a plain write stores
  localparam logic [31:0] MODE_WMASK = 32'hf0e70000;
  // enable bit of the control word
  localparam int POS_EN = 0;
  // interrupt status bit positions
  localparam int IRQ_EDGE = 0;
  localparam int IRQ_OVF = 1;
  // count source encodings
  localparam logic [2:0] CS_DIV1 = 3'h0;
  localparam logic [2:0] CS_DIV8 = 3'h1;
  localparam logic [2:0] CS_DIV32 = 3'h2;
  localparam logic [2:0] CS_DIV128 = 3'h3;
  localparam logic [2:0] CS_EXT = 3'h6;
  // measured edge encodings
  localparam logic [2:0] ME_RISE = 3'h1;
  localparam logic [2:0] ME_FALL = 3'h2;
  localparam logic [2:0] ME_BOTH = 3'h3;
  // terminal count values
  localparam logic [15:0] TC_LOW = 16'h0000;
  localparam logic [15:0] TC_HIGH = 16'hffff;
  // reset values
  localparam logic [31:0] RST_MODE = 32'h00000000;
  localparam logic [15:0] RST_REL = 16'h0000;
  localparam logic [15:0] RST_CNT = 16'h0000;
  // register bus request carrier
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ppw_bus_req_t;
endpackage : ppw_pkg

// *** rtl/ppw_capture.sv ***
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
// period and pulse width capture channel
module ppw_capture (
  input wire logic core_clk,
  input wire logic rst,
  input ppw_pkg::ppw_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  input wire logic measured_wave_pin,
  input wire logic ext_count_pin,
  output logic irq,
  output logic dma_req
);

  // whole module state
  typedef struct packed {
    logic wave_s1; // first sync stage of measured pin
    logic wave_s2; // second sync stage
    logic wave_d; // delayed copy for edge detect
    logic ext_s1; // first sync stage of count pin
    logic ext_s2; // second sync stage
    logic ext_d; // delayed copy for edge detect
    logic [6:0] presc; // free running prescaler
    logic [31:0] mode; // mode word, fields in the upper half
    logic enable; // channel enable
    logic [15:0] reload; // starting value of counter
    logic [15:0] cmprld; // compare value and capture result
    logic [15:0] count; // measurement counter
    logic first_done; // first measured edge already seen
    logic [1:0] istat; // sticky interrupt causes
    logic [1:0] ien; // interrupt enables
    logic dma; // one cycle dma request
    logic [31:0] rdata; // read data for the cycle after a read
  } ppw_state_t;

  ppw_state_t state_reg; // registered state
  ppw_state_t state_next; // next state
  logic tick; // count source active edge
  logic wave_rise; // measured pin rising edge
  logic wave_fall; // measured pin falling edge
  logic meas_mode; // measurement mode selected
  logic meas_hit; // selected measured edge while running
  logic meas_req; // measured edge that raises a request
  logic at_tc; // counter sits at terminal count
  logic ovf_hit; // tick taken at terminal count
  logic [2:0] csrc; // count source field
  logic [2:0] edge_sel; // measured edge field
  logic wr_mode; // write to mode word
  logic wr_cmprld; // write to capture register
  logic flag_wr; // masked write to the flag bits

  // field views and decoded strobes
  assign csrc = state_reg.mode[ppw_pkg::POS_CSRC_LO +: 3];
  assign edge_sel = state_reg.mode[ppw_pkg::POS_EDGE_LO +: 3];
  assign wr_mode = bus_req.wr && (bus_req.addr == ppw_pkg::OFF_MODE);
  assign wr_cmprld = bus_req.wr && (bus_req.addr == ppw_pkg::OFF_CMPRLD);
  assign flag_wr = wr_mode && bus_req.wdata[ppw_pkg::POS_FMASK];

  // edge detection on synchronised pins
  always_comb begin
    wave_rise = state_reg.wave_s2 && !state_reg.wave_d;
    wave_fall = !state_reg.wave_s2 && state_reg.wave_d;
  end

  // count source selection
  always_comb begin
    // RULE7 - source field decode
    case (csrc)
      ppw_pkg::CS_DIV1: tick = 1'b1;
      ppw_pkg::CS_DIV8: tick = &state_reg.presc[2:0];
      ppw_pkg::CS_DIV32: tick = &state_reg.presc[4:0];
      ppw_pkg::CS_DIV128: tick = &state_reg.presc;
      // RULE18 - synchronised pin edge
      ppw_pkg::CS_EXT: tick = state_reg.ext_s2 && !state_reg.ext_d;
      default: tick = 1'b0;
    endcase
  end

  // mode decode and measured edge selection
  always_comb begin
    // RULE10 - input type, measurement mode
    meas_mode = !state_reg.mode[ppw_pkg::POS_TYPE] && state_reg.mode[ppw_pkg::POS_OPMODE];
    // RULE12 - edge field decode
    case (edge_sel)
      ppw_pkg::ME_RISE: meas_hit = wave_rise;
      ppw_pkg::ME_FALL: meas_hit = wave_fall;
      ppw_pkg::ME_BOTH: meas_hit = wave_rise || wave_fall;
      default: meas_hit = 1'b0;
    endcase
    // RULE17 - only while enabled
    meas_hit = meas_hit && meas_mode && state_reg.enable;
    // RULE14 - first edge is silent
    meas_req = meas_hit && state_reg.first_done;
  end

  // terminal count and overflow detection
  always_comb begin
    // RULE11 - terminal count choice
    if (state_reg.mode[ppw_pkg::POS_TCC]) begin
      at_tc = (state_reg.count == ppw_pkg::TC_LOW) || (state_reg.count >= state_reg.cmprld);
    end else begin
      at_tc = (state_reg.count == ppw_pkg::TC_LOW) || (state_reg.count == ppw_pkg::TC_HIGH);
    end
    // RULE5 - tick following terminal count
    ovf_hit = tick && at_tc && meas_mode && state_reg.enable && !meas_hit;
  end

  // next state
  always_comb begin
    state_next = state_reg;
    // two flop synchronisers and edge delay
    state_next.wave_s1 = measured_wave_pin;
    state_next.wave_s2 = state_reg.wave_s1;
    state_next.wave_d = state_reg.wave_s2;
    state_next.ext_s1 = ext_count_pin;
    state_next.ext_s2 = state_reg.ext_s1;
    state_next.ext_d = state_reg.ext_s2;
    state_next.presc = state_reg.presc + 7'h01;
    state_next.dma = 1'b0;
    state_next.rdata = 32'h00000000;
    // software writes
    if (wr_mode) begin
      state_next.mode = (bus_req.wdata & ppw_pkg::MODE_WMASK)
                        | (state_reg.mode & ~ppw_pkg::MODE_WMASK);
      // RULE13 - flags follow only with mask
      if (bus_req.wdata[ppw_pkg::POS_FMASK]) begin
        state_next.mode[ppw_pkg::POS_UFLAG] = bus_req.wdata[ppw_pkg::POS_UFLAG];
        state_next.mode[ppw_pkg::POS_OFLAG] = bus_req.wdata[ppw_pkg::POS_OFLAG];
      end
    end
    // enable write
    if (bus_req.wr && (bus_req.addr == ppw_pkg::OFF_CTRL)) begin
      state_next.enable = bus_req.wdata[ppw_pkg::POS_EN];
    end
    // reload value write
    if (bus_req.wr && (bus_req.addr == ppw_pkg::OFF_RELOAD)) begin
      state_next.reload = bus_req.wdata[15:0];
    end
    // RULE9 - rewrite refused while running
    if (wr_cmprld && !state_reg.enable) begin
      state_next.cmprld = bus_req.wdata[15:0];
    end
    // interrupt enable write
    if (bus_req.wr && (bus_req.addr == ppw_pkg::OFF_IEN)) begin
      state_next.ien = bus_req.wdata[1:0];
    end
    // status clear, a set in the same cycle below wins
    if (bus_req.wr && (bus_req.addr == ppw_pkg::OFF_ICLR)) begin
      state_next.istat = state_reg.istat & ~bus_req.wdata[1:0];
    end
    // stopped channel forgets the first edge
    if (!state_reg.enable) begin
      state_next.first_done = 1'b0;
    end
    // counting and capture
    if (meas_hit) begin
      // RULE2 - capture counter value
      state_next.cmprld = state_reg.count;
      // RULE3 - reload counter
      state_next.count = state_reg.reload;
      state_next.first_done = 1'b1;
    end else if (tick && meas_mode && state_reg.enable) begin
      // RULE6 - up count, wraps at top
      state_next.count = state_reg.count + 16'h0001;
    end
    // RULE15 - flag marks only overflow
    if (ovf_hit) begin
      state_next.mode[ppw_pkg::POS_OFLAG] = 1'b1;
      state_next.istat[ppw_pkg::IRQ_OVF] = 1'b1;
    end
    if (meas_req) begin
      state_next.istat[ppw_pkg::IRQ_EDGE] = 1'b1;
    end
    // RULE4 - request on both causes
    if (ovf_hit || meas_req) begin
      state_next.dma = 1'b1;
    end
    // read data, answered the next cycle
    if (bus_req.rd) begin
      case (bus_req.addr)
        ppw_pkg::OFF_MODE: state_next.rdata = state_reg.mode & ~(32'h1 << ppw_pkg::POS_FMASK);
        ppw_pkg::OFF_CTRL: state_next.rdata = {31'h0, state_reg.enable};
        ppw_pkg::OFF_RELOAD: state_next.rdata = {16'h0, state_reg.reload};
        ppw_pkg::OFF_CMPRLD: state_next.rdata = {16'h0, state_reg.cmprld};
        ppw_pkg::OFF_COUNT: state_next.rdata = {16'h0, state_reg.count};
        ppw_pkg::OFF_ISTAT: state_next.rdata = {30'h0, state_reg.istat};
        ppw_pkg::OFF_IEN: state_next.rdata = {30'h0, state_reg.ien};
        // unmapped and write only offsets read zero
        default: state_next.rdata = 32'h00000000;
      endcase
    end
  end

  // state register with synchronous reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.mode <= ppw_pkg::RST_MODE;
      state_reg.reload <= ppw_pkg::RST_REL;
      state_reg.count <= ppw_pkg::RST_CNT;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs
  assign bus_rdata = state_reg.rdata;
  assign dma_req = state_reg.dma;
  assign irq = |(state_reg.istat & state_reg.ien);

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // RULE2 - captured value check
  a_capture_count_value: assert property ( // RULE2
    meas_hit |=> state_reg.cmprld == $past(state_reg.count))
    else $error("capture did not hold counter value");

  // RULE3 - reload check
  a_reload_on_edge: assert property ( // RULE3
    meas_hit |=> state_reg.count == $past(state_reg.reload))
    else $error("counter not reloaded on measured edge");

  // RULE4 - request after each event
  a_request_on_event: assert property ( // RULE4
    (ovf_hit || meas_req) |=> dma_req)
    else $error("request missing after event");

  // RULE4 - no request without event
  a_request_only_event: assert property ( // RULE4
    !ovf_hit && !meas_req |=> !dma_req)
    else $error("request without event or too long");

  // RULE5 - overflow keeps counting
  a_overflow_keeps_count: assert property ( // RULE5
    ovf_hit |=> state_reg.mode[ppw_pkg::POS_OFLAG]
      && state_reg.count == 16'($past(state_reg.count) + 16'h0001))
    else $error("overflow did not set flag or stopped count");

  // RULE9 - locked while running
  a_cmprld_locked_run: assert property ( // RULE9
    wr_cmprld && state_reg.enable && !meas_hit |=> $stable(state_reg.cmprld))
    else $error("capture register rewritten while running");

  // RULE13 - flag untouched without mask
  a_flag_mask_hold: assert property ( // RULE13
    wr_mode && !bus_req.wdata[ppw_pkg::POS_FMASK] && !ovf_hit
      |=> $stable(state_reg.mode[ppw_pkg::POS_OFLAG]))
    else $error("flag changed without write mask");

  // RULE14 - first edge quiet
  a_first_edge_quiet: assert property ( // RULE14
    meas_hit && !state_reg.first_done && !ovf_hit |=> !dma_req)
    else $error("first measured edge raised a request");

  // RULE17 - stopped counter holds
  a_stopped_count_hold: assert property ( // RULE17
    !state_reg.enable |=> $stable(state_reg.count))
    else $error("counter moved while disabled");

  // RULE15 - edge leaves flag alone
  a_edge_not_flagged: assert property ( // RULE15
    meas_req && !wr_mode |=> $stable(state_reg.mode[ppw_pkg::POS_OFLAG]))
    else $error("measured edge set overflow flag");

  // RULE7 - divide by eight spacing
  a_div8_spacing: assert property ( // RULE7
    csrc == ppw_pkg::CS_DIV8 && tick && !wr_mode |=> !tick [*7])
    else $error("divide by eight ticks too close");

  // RULE7 - divide by thirty two, no tick in the seven cycles after a tick
  a_div32_spacing: assert property ( // RULE7
    csrc == ppw_pkg::CS_DIV32 && tick && !wr_mode |=> !tick [*7])
    else $error("divide by thirty two ticks too close");

  // RULE18 - tick steps counter
  a_tick_steps_count: assert property ( // RULE18
    tick && meas_mode && state_reg.enable && !meas_hit
      |=> state_reg.count == 16'($past(state_reg.count) + 16'h0001))
    else $error("counter missed a source tick");

  // RULE18 - no tick, no step
  a_idle_count_hold: assert property ( // RULE18
    !meas_hit && !(tick && meas_mode && state_reg.enable) |=> $stable(state_reg.count))
    else $error("counter moved without tick or edge");

  // RULE11 - zero is terminal count
  a_tc_zero_overflow: assert property ( // RULE11
    tick && meas_mode && state_reg.enable && !meas_hit && state_reg.count == ppw_pkg::TC_LOW
      |=> state_reg.mode[ppw_pkg::POS_OFLAG] && state_reg.istat[ppw_pkg::IRQ_OVF])
    else $error("tick at zero did not overflow");

  // RULE11 - compare bound is terminal count
  a_tc_compare_overflow: assert property ( // RULE11
    state_reg.mode[ppw_pkg::POS_TCC] && tick && meas_mode && state_reg.enable && !meas_hit
      && state_reg.count >= state_reg.cmprld |=> state_reg.istat[ppw_pkg::IRQ_OVF])
    else $error("tick at compare bound did not overflow");

  // RULE11 - plain range flags only at zero or top
  a_tc_plain_quiet: assert property ( // RULE11
    !state_reg.mode[ppw_pkg::POS_TCC] && state_reg.count != ppw_pkg::TC_LOW
      && state_reg.count != ppw_pkg::TC_HIGH && !flag_wr
      |=> $stable(state_reg.mode[ppw_pkg::POS_OFLAG]))
    else $error("overflow flag set away from terminal count");

  // RULE14 - edge status needs request
  a_edge_status_cause: assert property ( // RULE14
    $rose(state_reg.istat[ppw_pkg::IRQ_EDGE]) |-> $past(meas_req))
    else $error("edge status set without counted edge");

  // RULE15 - overflow status cause
  a_ovf_status_cause: assert property ( // RULE15
    $rose(state_reg.istat[ppw_pkg::IRQ_OVF]) |-> $past(ovf_hit))
    else $error("overflow status set without overflow");

  // RULE15 - flag set cause
  a_flag_set_cause: assert property ( // RULE15
    $rose(state_reg.mode[ppw_pkg::POS_OFLAG]) |-> $past(ovf_hit) || $past(flag_wr))
    else $error("overflow flag set without overflow");

  // RULE14 - stopped channel silent
  a_disabled_no_request: assert property ( // RULE14
    !state_reg.enable |=> !dma_req)
    else $error("request while channel stopped");

  // RULE10 - other modes stay quiet
  a_mode_off_quiet: assert property ( // RULE10
    !meas_mode |=> !dma_req && $stable(state_reg.count))
    else $error("activity outside measurement mode");

  // RULE4 - edge request sets status
  a_edge_sets_status: assert property ( // RULE4
    meas_req |=> state_reg.istat[ppw_pkg::IRQ_EDGE])
    else $error("edge request left status clear");

  // RULE2 - capture holds between edges
  a_capture_hold_idle: assert property ( // RULE2
    !meas_hit && !(wr_cmprld && !state_reg.enable) |=> $stable(state_reg.cmprld))
    else $error("capture register changed between edges");

  // main scenarios
  c_period_capture: cover property (meas_req ##1 irq);
  c_overflow_event: cover property (ovf_hit ##1 state_reg.mode[ppw_pkg::POS_OFLAG]);
  c_ext_source_count: cover property (csrc == ppw_pkg::CS_EXT && tick && meas_mode);
  c_width_capture: cover property (edge_sel == ppw_pkg::ME_BOTH && meas_req);
  c_flag_clear: cover property (
    state_reg.mode[ppw_pkg::POS_OFLAG] && wr_mode && bus_req.wdata[ppw_pkg::POS_FMASK]);

endmodule : ppw_capture

// *** testbench/period_pulse_width_capture_tb.sv ***
`timescale 1ns/1ps
// self checking bench for the capture channel
module period_pulse_width_capture_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  ppw_pkg::ppw_bus_req_t bus_req = '0;
  logic [31:0] bus_rdata;
  logic irq;
  logic dma_req;
  logic wave_pin;
  logic ext_pin;
  logic wave_run = 1'b0;
  logic ext_run = 1'b0;
  logic [31:0] rv;
  logic [31:0] a;
  logic [15:0] r;
  logic [23:0] lfsr = 24'd82618;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int dma_cnt = 0;
  int rise_q[$];
  int rises = 0;
  int d0;
  int r0;
  int dv[4] = '{8, 32, 128, 4};
  logic [2:0] cs[4] = '{ppw_pkg::CS_DIV8, ppw_pkg::CS_DIV32, ppw_pkg::CS_DIV128, ppw_pkg::CS_EXT};
  // clock
  always #2.5 core_clk = ~core_clk;
  ppw_capture i_dut (.core_clk(core_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .measured_wave_pin(wave_pin), .ext_count_pin(ext_pin), .irq(irq), .dma_req(dma_req));
  ppw_wave_src i_src (.core_clk(core_clk), .wave_run(wave_run), .ext_run(ext_run),
    .measured_wave_pin(wave_pin), .ext_count_pin(ext_pin));
  // request pulses and cycle count, plus the hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (dma_req === 1'b1) dma_cnt++;
    if (cycles == 8000) begin
      err_count++;
      print_verdict();
    end
  end
  // model: cycle stamp of every measured rise
  always @(posedge wave_pin) begin
    rises++;
    rise_q.push_back(cycles);
  end
  function automatic logic [23:0] lfsr_step(input logic [23:0] s);
    return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
  endfunction : lfsr_step
  // mode word: measure mode, up count, given edge and source
  function automatic logic [31:0] mw(input logic [2:0] e, input logic [2:0] c);
    return {c, 1'b1, 4'h0, e, 3'h0, 1'b1, 1'b0, 16'h0000};
  endfunction : mw
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    @(posedge core_clk);
    bus_req <= '{addr: ad, wdata: wd, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask : wr
  // read data stands in the cycle after the strobe
  task automatic rd(input logic [7:0] ad);
    @(posedge core_clk);
    bus_req <= '{addr: ad, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1 rv = bus_rdata;
  endtask : rd
  task automatic print_verdict();
    if (err_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    foreach (cs[i]) begin
      rd(8'h20 - 8'(i) * 8'h0c);
      check(rv, 32'h0);
    end
    lfsr = lfsr_step(lfsr);
    r = {4'h0, lfsr[11:0]};
    wr(ppw_pkg::OFF_RELOAD, {16'h0, r});
    wr(ppw_pkg::OFF_IEN, 32'h1);
    wr(ppw_pkg::OFF_MODE, mw(ppw_pkg::ME_RISE, ppw_pkg::CS_DIV1));
    wr(ppw_pkg::OFF_CTRL, 32'h1);
    repeat (10) @(posedge core_clk);
    d0 = dma_cnt;
    r0 = rises;
    wave_run <= 1'b1;
    repeat (160) @(posedge core_clk);
    wave_run <= 1'b0;
    repeat (10) @(posedge core_clk);
    check(dma_cnt - d0, rises - r0 - 1);
    rd(ppw_pkg::OFF_CMPRLD);
    check(rv, r + 32'd31);
    check(rv, {16'h0, r} + 32'(rise_q[$] - rise_q[$-1] - 1));
    check(32'(rv >= {16'h0, r} && rv < {16'h0, r} + 32'd64), 32'h1);
    rd(ppw_pkg::OFF_ISTAT);
    check(rv & 32'h1, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(ppw_pkg::OFF_ICLR, 32'h1);
    @(posedge core_clk);
    #1 check({31'h0, irq}, 32'h0);
    rd(ppw_pkg::OFF_MODE);
    check({31'h0, rv[26]}, 32'h1);
    wr(ppw_pkg::OFF_MODE, mw(ppw_pkg::ME_RISE, ppw_pkg::CS_DIV1));
    rd(ppw_pkg::OFF_MODE);
    check({31'h0, rv[26]}, 32'h1);
    wr(ppw_pkg::OFF_MODE, mw(ppw_pkg::ME_RISE, ppw_pkg::CS_DIV1) | 32'h01000000);
    rd(ppw_pkg::OFF_MODE);
    check({31'h0, rv[26]}, 32'h0);
    wr(ppw_pkg::OFF_CMPRLD, 32'h1234);
    rd(ppw_pkg::OFF_CMPRLD);
    check(rv, r + 32'd31);
    // rise, fall and both edge measurements
    for (int e = 1; e < 4; e++) begin
      wr(ppw_pkg::OFF_MODE, mw(3'(e), ppw_pkg::CS_DIV1));
      wave_run <= 1'b1;
      repeat (130) @(posedge core_clk);
      wave_run <= 1'b0;
      repeat (10) @(posedge core_clk);
      rd(ppw_pkg::OFF_CMPRLD);
      check(32'(e < 3 ? rv == r + 31 : (rv == r + 11 || rv == r + 19)), 32'h1);
      rd(ppw_pkg::OFF_MODE);
      check({31'h0, rv[26]}, 32'h0);
    end
    // divided and external count sources
    foreach (cs[i]) begin
      wr(ppw_pkg::OFF_MODE, mw(ppw_pkg::ME_RISE, cs[i]));
      ext_run <= (i == 3);
      rd(ppw_pkg::OFF_COUNT);
      a = rv;
      repeat (510) @(posedge core_clk);
      rd(ppw_pkg::OFF_COUNT);
      check(32'((rv - a) + 1 >= 512 / dv[i] && (rv - a) <= 512 / dv[i] + 1), 32'h1);
    end
    ext_run <= 1'b0;
    wr(ppw_pkg::OFF_CTRL, 32'h0);
    rd(ppw_pkg::OFF_COUNT);
    a = rv;
    repeat (50) @(posedge core_clk);
    rd(ppw_pkg::OFF_COUNT);
    check(rv, a);
    // drop the old overflow status so the next check means something
    wr(ppw_pkg::OFF_ICLR, 32'h2);
    // reload near the top, then let the counter run over
    wr(ppw_pkg::OFF_RELOAD, 32'hffc0);
    wr(ppw_pkg::OFF_MODE, mw(ppw_pkg::ME_RISE, ppw_pkg::CS_DIV1));
    wr(ppw_pkg::OFF_CTRL, 32'h1);
    wave_run <= 1'b1;
    repeat (40) @(posedge core_clk);
    wave_run <= 1'b0;
    repeat (110) @(posedge core_clk);
    rd(ppw_pkg::OFF_MODE);
    check({31'h0, rv[26]}, 32'h1);
    rd(ppw_pkg::OFF_ISTAT);
    check(rv & 32'h2, 32'h2);
    rd(ppw_pkg::OFF_COUNT);
    check(32'(rv > 0 && rv < 32'h100), 32'h1);
    wr(ppw_pkg::OFF_IEN, 32'h0);
    @(posedge core_clk);
    #1 check({31'h0, irq}, 32'h0);
    wr(ppw_pkg::OFF_IEN, 32'h2);
    @(posedge core_clk);
    #1 check({31'h0, irq}, 32'h1);
    // compare bound terminal count, bound written while stopped
    wr(ppw_pkg::OFF_CTRL, 32'h0);
    wr(ppw_pkg::OFF_CMPRLD, 32'h00c0);
    rd(ppw_pkg::OFF_CMPRLD);
    check(rv, 32'h00c0);
    wr(ppw_pkg::OFF_MODE, mw(ppw_pkg::ME_RISE, ppw_pkg::CS_DIV1) | 32'h01040000);
    wr(ppw_pkg::OFF_ICLR, 32'h2);
    wr(ppw_pkg::OFF_CTRL, 32'h1);
    repeat (200) @(posedge core_clk);
    rd(ppw_pkg::OFF_MODE);
    check({31'h0, rv[26]}, 32'h1);
    rd(ppw_pkg::OFF_ISTAT);
    check(rv & 32'h2, 32'h2);
    print_verdict();
  end
endmodule : period_pulse_width_capture_tb

// *** testbench/ppw_wave_src.sv ***
`timescale 1ns/1ps
// far side model: measured waveform source and external count clock
module ppw_wave_src #(
  parameter int HI_LEN = 12,
  parameter int LO_LEN = 20
) (
  input wire logic core_clk,
  input wire logic wave_run,
  input wire logic ext_run,
  output logic measured_wave_pin,
  output logic ext_count_pin
);
  // cycles spent at the present wave level
  int lvl_cnt;
  // count pin toggles every second cycle
  logic ext_ph;
  initial begin
    measured_wave_pin = 1'b0;
    ext_count_pin = 1'b0;
    lvl_cnt = 0;
    ext_ph = 1'b0;
  end
  // wave toggles after each level length, holds its level while stopped
  always @(posedge core_clk) begin
    if (wave_run) begin
      lvl_cnt <= lvl_cnt + 1;
      if (lvl_cnt + 1 >= (measured_wave_pin ? HI_LEN : LO_LEN)) begin
        measured_wave_pin <= ~measured_wave_pin;
        lvl_cnt <= 0;
      end
    end
  end
  // quarter clock rate, pin stands low while stopped
  always @(posedge core_clk) begin
    if (ext_run) begin
      ext_ph <= ~ext_ph;
      if (ext_ph) begin
        ext_count_pin <= ~ext_count_pin;
      end
    end else begin
      ext_ph <= 1'b0;
      ext_count_pin <= 1'b0;
    end
  end
endmodule : ppw_wave_src
